// ===== rtl/fsol_filter.v
// glitch filter: output follows input once stable for a count
`timescale 1ns/1ps
`default_nettype none
module fsol_filter #(
   parameter integer CYC = 4,
   parameter integer W   = 12
) (
   input  wire mclk_i,
   input  wire arst_n_i,
   input  wire raw_i,
   output reg  filt_o
);
   reg [W-1:0] cnt_q;
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q  <= {W{1'b0}};
         filt_o <= 1'b1;
      end else if (raw_i == filt_o) begin
         cnt_q <= {W{1'b0}};
      end else if (cnt_q == CYC[W-1:0] - {{(W-1){1'b0}}, 1'b1}) begin
         cnt_q  <= {W{1'b0}};
         filt_o <= raw_i;
      end else begin
         cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule
`default_nettype wire

// ===== rtl/fsol_regs.vh
// constants of the fail-safe output and input logic
//
// Contract
// - any failure sets fail outputs and active flag
// - failures: watchdog, thermal, supply short, reset clamp
// - select bit picks one or two watchdog failures
// - release needs no failure and flag cleared
// - watchdog activation released only after watchdog flag clear
// - every listed failure triggers, any mode
// - outputs activate together; static output holds low (code: dim follows its free-running phase, so may start off)
// - blink output 1.25 Hz, 50 percent duty
// - dim output 100 Hz, 20 percent duty
// - pull-up enables depend on mode and disable bit
// - blink pin doubles as fail-safe input
// - rising edge required within 240 us window
// - supervision on after reset, off by disable bit
// - missing edge sets flag, activates static and dim
// - input failure changes no mode, no reset, interrupt
// - missing flag clear accepted only after new edge
// - supervision runs only in normal mode
// - input filtered at most 1.5 us
// - test select input filtered 16 us
`ifndef FSOL_REGS_VH
`define FSOL_REGS_VH
`define FSOL_CLK_KHZ        40000
`define FSOL_BLINK_HZ_X100  125
`define FSOL_DIM_HZ         100
`define FSOL_BLINK_PER      (`FSOL_CLK_KHZ * 1000 / `FSOL_BLINK_HZ_X100 * 100)
`define FSOL_BLINK_HALF     (`FSOL_BLINK_PER / 2)
`define FSOL_DIM_PER        (`FSOL_CLK_KHZ * 1000 / `FSOL_DIM_HZ)
`define FSOL_DIM_DUTY_PCT   20
`define FSOL_DIM_ON         (`FSOL_DIM_PER * `FSOL_DIM_DUTY_PCT / 100)
`define FSOL_FSI_WIN_US     240
`define FSOL_FSI_WIN_CYC    (`FSOL_FSI_WIN_US * `FSOL_CLK_KHZ / 1000)
`define FSOL_FSI_FILT_NS    1500
`define FSOL_FSI_FILT_CYC   (`FSOL_FSI_FILT_NS * `FSOL_CLK_KHZ / 1000000)
`define FSOL_TEST_FILT_US   16
`define FSOL_TEST_FILT_CYC  (`FSOL_TEST_FILT_US * `FSOL_CLK_KHZ / 1000)
`define FSOL_MODE_INIT      2'h0
`define FSOL_MODE_NORMAL    2'h1
`define FSOL_MODE_OTHER     2'h2
`define FSOL_RST_FLAG       1'b0
`define FSOL_RST_OUT        1'b0
`define FSOL_RST_PIN        1'b1
`endif

// ===== rtl/fsol_top.v
// fail output driver and fail-safe input supervisor
`timescale 1ns/1ps
`default_nettype none
`include "fsol_regs.vh"
module fsol_top #(
   parameter integer BLINK_HALF = `FSOL_BLINK_HALF,
   parameter integer DIM_PER    = `FSOL_DIM_PER,
   parameter integer DIM_ON     = `FSOL_DIM_ON,
   parameter integer FSI_WIN    = `FSOL_FSI_WIN_CYC
) (
   input  wire       mclk_i,
   input  wire       arst_n_i,
   input  wire [1:0] mode_i,
   input  wire       watchdog_fail_flag_pulse_i,
   input  wire       watchdog_fail_flag_flag_i,
   input  wire       thermal_shutdown_level2_i,
   input  wire       main_supply_short_i,
   input  wire       reset_output_clamped_i,
   input  wire       fo_wd_count_select_i,
   input  wire       fsi_disable_i,
   input  wire       fo_active_clr_i,
   input  wire       fsi_missing_clr_i,
   input  wire       failsafe_input_i,
   input  wire       test_sel_i,
   output reg        fail_out_static_oe_o,
   output reg        fail_out_blink_oe_o,
   output reg        fail_out_dim_oe_o,
   output reg        fail_out_static_pu_o,
   output reg        fail_out_blink_pu_o,
   output reg        fail_out_dim_pu_o,
   output reg        fail_out_active_flag_o,
   output reg        fsi_missing_flag_o,
   output reg        test_sel_filt_o
);
   // -------------------------------------------------------------
   // input filters
   // -------------------------------------------------------------
   wire fsi_filt;
   wire test_filt;
   fsol_filter #(.CYC(`FSOL_FSI_FILT_CYC), .W(12)) u_fsi_filt (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .raw_i    (failsafe_input_i),
      .filt_o   (fsi_filt)
   );
   fsol_filter #(.CYC(`FSOL_TEST_FILT_CYC), .W(12)) u_test_filt (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .raw_i    (test_sel_i),
      .filt_o   (test_filt)
   );

   // -------------------------------------------------------------
   // mode decode
   // -------------------------------------------------------------
   wire normal = (mode_i == `FSOL_MODE_NORMAL);
   wire init   = (mode_i == `FSOL_MODE_INIT);
   // supervision counts only in normal mode and while enabled
   wire fsi_on = normal & ~fsi_disable_i;

   // -------------------------------------------------------------
   // watchdog failure counting
   // -------------------------------------------------------------
   reg  wd_cnt_q;
   reg  wd_cnt_d;
   reg  wd_act_q;
   reg  wd_act_d;
   // second failure fires when the select bit asks for two
   wire wd_fire = watchdog_fail_flag_pulse_i &
                  (~fo_wd_count_select_i | wd_cnt_q);
   // served watchdog plus a clear ends a watchdog activation
   wire wd_free = ~watchdog_fail_flag_flag_i & fo_active_clr_i;
   // unserved watchdog keeps the active flag from clearing
   wire wd_keep = wd_act_q & watchdog_fail_flag_flag_i;

   always @* begin
      wd_cnt_d = wd_cnt_q;
      if (wd_fire) begin
         wd_cnt_d = 1'b0;
      end else if (watchdog_fail_flag_pulse_i) begin
         wd_cnt_d = 1'b1;
      end else if (wd_free) begin
         wd_cnt_d = 1'b0;
      end
   end

   always @* begin
      wd_act_d = wd_act_q;
      if (wd_fire) begin
         wd_act_d = 1'b1;
      end else if (wd_free) begin
         wd_act_d = 1'b0;
      end
   end

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wd_cnt_q <= `FSOL_RST_FLAG;
      end else begin
         wd_cnt_q <= wd_cnt_d;
      end
   end

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wd_act_q <= `FSOL_RST_FLAG;
      end else begin
         wd_act_q <= wd_act_d;
      end
   end

   // -------------------------------------------------------------
   // active flag
   // -------------------------------------------------------------
   reg  act_d;
   // a clear that meets a level failure is lost, not queued
   wire cond = thermal_shutdown_level2_i | main_supply_short_i |
               reset_output_clamped_i;
   wire trig = cond | wd_fire;

   // set wins over clear; release only once nothing is present
   always @* begin
      act_d = fail_out_active_flag_o;
      if (trig) begin
         act_d = 1'b1;
      end else if (fo_active_clr_i && !wd_keep) begin
         act_d = 1'b0;
      end
   end

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fail_out_active_flag_o <= `FSOL_RST_FLAG;
      end else begin
         fail_out_active_flag_o <= act_d;
      end
   end

   // -------------------------------------------------------------
   // fail-safe input edge detect
   // -------------------------------------------------------------
   reg  fsi_prev_q;
   // reset matches the filter's idle high, so no false edge
   wire fsi_ris = fsi_filt & ~fsi_prev_q;

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fsi_prev_q <= `FSOL_RST_PIN;
      end else begin
         fsi_prev_q <= fsi_filt;
      end
   end

   // -------------------------------------------------------------
   // fail-safe input window timer
   // -------------------------------------------------------------
   reg  [13:0] win_q;
   reg  [13:0] win_d;
   wire        win_end = fsi_on & (win_q == FSI_WIN[13:0] - 14'h0001);

   // timer held at zero outside normal mode or when disabled
   always @* begin
      if (!fsi_on || fsi_ris || win_end) begin
         win_d = 14'h0000;
      end else begin
         win_d = win_q + 14'h0001;
      end
   end

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         win_q <= 14'h0000;
      end else begin
         win_q <= win_d;
      end
   end

   // -------------------------------------------------------------
   // missing edge flag
   // -------------------------------------------------------------
   reg  seen_q;
   reg  seen_d;
   reg  miss_d;
   wire miss_set = win_end & ~fsi_ris;
   // clear honoured only once an edge followed the flag
   wire miss_clr = fsi_missing_clr_i & (seen_q | fsi_ris);

   always @* begin
      miss_d = fsi_missing_flag_o;
      if (miss_set) begin
         miss_d = 1'b1;
      end else if (miss_clr) begin
         miss_d = 1'b0;
      end
   end

   always @* begin
      seen_d = seen_q;
      if (miss_set || miss_clr) begin
         seen_d = 1'b0;
      end else if (fsi_ris) begin
         seen_d = 1'b1;
      end
   end

   // no mode change, reset or interrupt comes from this path
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fsi_missing_flag_o <= `FSOL_RST_FLAG;
      end else begin
         fsi_missing_flag_o <= miss_d;
      end
   end

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         seen_q <= `FSOL_RST_FLAG;
      end else begin
         seen_q <= seen_d;
      end
   end

   // -------------------------------------------------------------
   // blink divider
   // -------------------------------------------------------------
   reg  [24:0] blink_q;
   reg  [24:0] blink_d;
   reg         blink_ph_q;
   reg         blink_ph_d;
   // one-cycle enable at each half period of the blink output
   wire        blink_tick = (blink_q == BLINK_HALF[24:0] - 25'h0000001);

   // restart so each activation begins with a low phase
   always @* begin
      if (!fail_out_active_flag_o || blink_tick) begin
         blink_d = 25'h0000000;
      end else begin
         blink_d = blink_q + 25'h0000001;
      end
   end

   always @* begin
      blink_ph_d = blink_ph_q;
      if (!fail_out_active_flag_o) begin
         blink_ph_d = 1'b0;
      end else if (blink_tick) begin
         blink_ph_d = ~blink_ph_q;
      end
   end

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         blink_q <= 25'h0000000;
      end else begin
         blink_q <= blink_d;
      end
   end

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         blink_ph_q <= 1'b0;
      end else begin
         blink_ph_q <= blink_ph_d;
      end
   end

   // -------------------------------------------------------------
   // dim divider
   // -------------------------------------------------------------
   reg  [18:0] dim_q;
   reg  [18:0] dim_d;
   // free running: an activation joins the period mid-way
   wire        dim_wrap = (dim_q == DIM_PER[18:0] - 19'h00001);
   wire        dim_hi   = (dim_q < DIM_ON[18:0]);

   always @* begin
      if (dim_wrap) begin
         dim_d = 19'h00000;
      end else begin
         dim_d = dim_q + 19'h00001;
      end
   end

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dim_q <= 19'h00000;
      end else begin
         dim_q <= dim_d;
      end
   end

   // -------------------------------------------------------------
   // low-side switches, oe high pulls the pin low
   // -------------------------------------------------------------
   wire any_act = fail_out_active_flag_o | fsi_missing_flag_o;

   // static follows either flag; dim is gated by its free-running phase, blink by its own
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fail_out_static_oe_o <= `FSOL_RST_OUT;
      end else begin
         fail_out_static_oe_o <= any_act;
      end
   end

   // blink stays off on a missing edge: its pin is the input
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fail_out_blink_oe_o <= `FSOL_RST_OUT;
      end else begin
         fail_out_blink_oe_o <= fail_out_active_flag_o & ~blink_ph_q;
      end
   end

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fail_out_dim_oe_o <= `FSOL_RST_OUT;
      end else begin
         fail_out_dim_oe_o <= any_act & dim_hi;
      end
   end

   // -------------------------------------------------------------
   // pull-up enables
   // -------------------------------------------------------------
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fail_out_static_pu_o <= `FSOL_RST_OUT;
      end else begin
         fail_out_static_pu_o <= init | normal;
      end
   end

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fail_out_blink_pu_o <= `FSOL_RST_OUT;
      end else begin
         fail_out_blink_pu_o <= (init | normal) & ~fsi_disable_i;
      end
   end

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fail_out_dim_pu_o <= `FSOL_RST_OUT;
      end else begin
         fail_out_dim_pu_o <= init;
      end
   end

   // -------------------------------------------------------------
   // filtered test select
   // -------------------------------------------------------------
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         test_sel_filt_o <= `FSOL_RST_PIN;
      end else begin
         test_sel_filt_o <= test_filt;
      end
   end
endmodule
`default_nettype wire

// ===== sim/fsol_assertions.sv
// checker of the fail output and fail-safe input logic
`timescale 1ns/1ps
`default_nettype none
module fsol_assertions (
   input wire logic       mclk_i,
   input wire logic       arst_n_i,
   input wire logic [1:0] mode_i,
   input wire logic       thermal_shutdown_level2_i,
   input wire logic       fsi_disable_i,
   input wire logic       fo_active_clr_i,
   input wire logic       fsi_missing_clr_i,
   input wire logic       fail_out_static_oe_o,
   input wire logic       fail_out_static_pu_o,
   input wire logic       fail_out_active_flag_o,
   input wire logic       fsi_missing_flag_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);
   property p_trig;
      thermal_shutdown_level2_i |=> fail_out_active_flag_o;
   endproperty
   a_trig: assert property (p_trig) else $error("no activation");
   property p_hold;
      fail_out_active_flag_o && !fo_active_clr_i |=> fail_out_active_flag_o;
   endproperty
   a_hold: assert property (p_hold) else $error("flag lost");
   property p_fall;
      $fell(fail_out_active_flag_o) |->
         $past(fo_active_clr_i) && !$past(thermal_shutdown_level2_i);
   endproperty
   a_fall: assert property (p_fall) else $error("bad release");
   property p_static;
      fail_out_active_flag_o || fsi_missing_flag_o |=> fail_out_static_oe_o;
   endproperty
   a_static: assert property (p_static) else $error("static off");
   property p_mhold;
      fsi_missing_flag_o && !fsi_missing_clr_i |=> fsi_missing_flag_o;
   endproperty
   a_mhold: assert property (p_mhold) else $error("miss lost");
   property p_norm;
      mode_i != 2'h1 && !fsi_missing_flag_o |=> !fsi_missing_flag_o;
   endproperty
   a_norm: assert property (p_norm) else $error("miss off-mode");
   property p_dis;
      fsi_disable_i && !fsi_missing_flag_o |=> !fsi_missing_flag_o;
   endproperty
   a_dis: assert property (p_dis) else $error("miss disabled");
   // guard: pull-up still shows reset value one edge after release
   property p_pu;
      $past(arst_n_i) && $stable(mode_i) |->
         fail_out_static_pu_o == (mode_i <= 2'h1);
   endproperty
   a_pu: assert property (p_pu) else $error("pull-up wrong");
endmodule
bind fsol_top fsol_assertions i_fsol_assertions (.mclk_i(mclk_i),
   .arst_n_i(arst_n_i), .mode_i(mode_i), .fsi_disable_i(fsi_disable_i),
   .thermal_shutdown_level2_i(thermal_shutdown_level2_i),
   .fo_active_clr_i(fo_active_clr_i), .fsi_missing_clr_i(fsi_missing_clr_i),
   .fail_out_static_oe_o(fail_out_static_oe_o),
   .fail_out_static_pu_o(fail_out_static_pu_o),
   .fail_out_active_flag_o(fail_out_active_flag_o),
   .fsi_missing_flag_o(fsi_missing_flag_o));
`default_nettype wire

// ===== sim/fsol_mcu.sv
// microcontroller model toggling the fail-safe input
`timescale 1ns/1ps
`default_nettype none
module fsol_mcu #(parameter integer HALF = 100) (
   input  wire logic mclk_i,
   input  wire logic run_i,
   output var  logic fsi_o
);
   integer n = 0;
   // stopped: pin pull-up holds it high, so no edges
   always @(posedge mclk_i) begin
      n <= (n >= HALF - 1) ? 0 : n + 1;
      if (!run_i) fsi_o <= 1'b1;
      else if (n == 0) fsi_o <= ~fsi_o;
   end
endmodule
`default_nettype wire

// ===== sim/fsol_top_tb.sv
// self-checking bench of the fail output and fail-safe input logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
 fail_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module fsol_top_tb;
   localparam integer W = 400;
   logic mclk_i = 0, arst_n_i = 0, wdp = 0, wdf = 0, sel = 0, dis = 0;
   logic aclr = 0, mclr = 0, tsel = 1, run = 0, so, bo, dmo, spu, bpu;
   logic dpu, af, mf, tf, mcu;
   logic [1:0] mode = 0;
   logic [2:0] fl = 0;
   wire failsafe_input = bo ? 1'b0 : mcu;
   integer fail_count = 0, samples_checked = 0, cyc = 0, i, k, c, d;
   integer seed = 32'h6653b93e;
   fsol_top #(.BLINK_HALF(20), .DIM_PER(50), .DIM_ON(10), .FSI_WIN(W))
   i_fsol_top (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .mode_i(mode),
      .watchdog_fail_flag_pulse_i(wdp), .watchdog_fail_flag_flag_i(wdf),
      .thermal_shutdown_level2_i(fl[0]), .main_supply_short_i(fl[1]),
      .reset_output_clamped_i(fl[2]), .fo_wd_count_select_i(sel),
      .fsi_disable_i(dis), .fo_active_clr_i(aclr), .fsi_missing_clr_i(mclr),
      .failsafe_input_i(failsafe_input), .test_sel_i(tsel), .fail_out_static_oe_o(so),
      .fail_out_blink_oe_o(bo), .fail_out_dim_oe_o(dmo),
      .fail_out_static_pu_o(spu), .fail_out_blink_pu_o(bpu),
      .fail_out_dim_pu_o(dpu), .fail_out_active_flag_o(af),
      .fsi_missing_flag_o(mf), .test_sel_filt_o(tf));
   fsol_mcu #(.HALF(100)) i_fsol_mcu (.mclk_i(mclk_i), .run_i(run),
      .fsi_o(mcu));
   always #12.5 mclk_i = ~mclk_i;
   // ceiling well above the longest sequence
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count++;
         conclude;
      end
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic tick(input integer n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic clr(input logic m);
      if (m) mclr <= 1; else aclr <= 1;
      tick(1);
      mclr <= 0;
      aclr <= 0;
   endtask
   function automatic logic wd_exp(input logic s, input integer n);
      wd_exp = !s || n == 1;
   endfunction
   function automatic logic [2:0] pu_exp(input integer m, input integer s);
      pu_exp = {m == 0, m <= 1 && s == 0, m <= 1};
   endfunction
   initial begin
      tick(6);
      arst_n_i <= 1;
      tick(2);
      `CHK("test filt", 1'b1, tf)
      for (i = 0; i < 3; i++) begin
         k = 3 + {$random(seed)} % 12;
         fl <= 3'h1 << i;
         tick(k);
         `CHK("active", 3'h7, {af, so, bo})
         c = 0;
         d = 0;
         repeat (200) begin
            tick(1);
            c += bo;
            d += dmo;
         end
         `CHK("blink", 100, c)
         `CHK("dim", 40, d)
         clr(0);
         fl <= 0;
         tick(3);
         `CHK("clr refused", 1'b1, af)
         clr(0);
         tick(3);
         `CHK("released", 2'h0, {af, so})
      end
      for (i = 0; i < 2; i++) begin
         sel <= i;
         wdf <= 1;
         for (k = 0; k < 2; k++) begin
            wdp <= 1;
            tick(1);
            wdp <= 0;
            tick(3);
            `CHK("wd count", wd_exp(sel, k), af)
         end
         clr(0);
         tick(3);
         `CHK("wd held", 1'b1, af)
         wdf <= 0;
         clr(0);
         tick(3);
         `CHK("wd free", 1'b0, af)
      end
      for (i = 0; i < 6; i++) begin
         mode <= i % 3;
         dis <= i / 3;
         tick(3);
         `CHK("pull", pu_exp(i % 3, i / 3), {dpu, bpu, spu})
      end
      mode <= 2'h1;
      dis <= 0;
      run <= 1;
      tick(1500);
      `CHK("fsi ok", 1'b0, mf)
      run <= 0;
      tick(W + 200);
      `CHK("fsi miss", 3'h6, {mf, so, bo})
      clr(1);
      tick(3);
      `CHK("miss kept", 1'b1, mf)
      run <= 1;
      tick(300);
      clr(1);
      tick(3);
      `CHK("miss clr", 1'b0, mf)
      dis <= 1;
      run <= 0;
      tick(W + 200);
      `CHK("fsi off", 1'b0, mf)
      dis <= 0;
      mode <= 2'h0;
      tick(W + 200);
      `CHK("fsi init", 1'b0, mf)
      tsel <= 0;
      tick(100 + {$random(seed)} % 400);
      `CHK("test short", 1'b1, tf)
      tick(600);
      `CHK("test long", 1'b0, tf)
      conclude;
   end
endmodule
`default_nettype wire
